/* tb/pcf_pin_model.sv */
// off-chip drivers of the pin-change and external interrupt pins
`timescale 1ns/100ps
`default_nettype none
module pcf_pin_model (
  // clock
  input  wire logic        clk_i,
  // levels asked for: [31:0] pin-change, [32] ext zero, [33] ext one
  input  wire logic [33:0] want_i,
  // pins
  output logic      [33:0] pin_o
);
  // registered, so no level lasts less than a whole clock
  always_ff @(posedge clk_i) begin
    pin_o <= want_i;
  end
endmodule : pcf_pin_model
`default_nettype wire

/* tb/test_pin_change_ext_irq_flags.sv */
// testbench: registers, pin-change groups and external flags
`timescale 1ns/100ps
`default_nettype none
module test_pin_change_ext_irq_flags;
  import pcf_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [33:0] want = '0;
  logic [33:0] pins;
  logic        gie_i = 1'b0;
  logic [1:0]  en_i = 2'h0;
  logic [1:0]  sc [2] = '{2'h1, 2'h1};
  pcf_ds_req_t ds = '0;
  pcf_io_req_t io = '0;
  logic [7:0]  rdata_o;
  logic [5:0]  irq_req_o;
  logic [5:0]  ack = 6'h00;
  logic [31:0] seed = 32'hAAE7;
  logic [7:0]  q;
  logic [7:0]  m_pc = 8'h00;
  logic [7:0]  m_ext = 8'h00;
  logic [15:0] mofs [4] = '{PCF_OFS_MASK0, PCF_OFS_MASK1, PCF_OFS_MASK2,
                            PCF_OFS_MASK3};
  logic [15:0] all [8] = '{PCF_OFS_PC_FLAGS, PCF_OFS_EXT_FLAGS,
                           PCF_OFS_GRP_EN, PCF_OFS_MASK0, PCF_OFS_MASK1,
                           PCF_OFS_MASK2, PCF_OFS_MASK3, 16'h0070};
  int          mismatches = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          msk [4] = '{0, 0, 0, 0};

  pcf_pin_model u_pins (.clk_i(clk_i), .want_i(want), .pin_o(pins));

  // device under test, pins come through the off-chip model
  pcf_irq_flags dut (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .pin_change_source_i  (pins[31:0]),
    .ext_irq_pin_zero_i   (pins[32]),
    .ext_irq_pin_one_i    (pins[33]),
    .gie_i                (gie_i),
    .ext_irq_enable_i     (en_i),
    .sense_control_zero_i (sc[0]),
    .sense_control_one_i  (sc[1]),
    .ds_req_i             (ds),
    .io_req_i             (io),
    .rdata_o              (rdata_o),
    .irq_req_o            (irq_req_o),
    .irq_ack_i            (ack)
  );

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  // xorshift source of random stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // wait n edges, then step 1 ns off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // one compare; four-state so an unknown fails
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // register write; a spare cycle keeps strobes of two calls apart
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input bit sio);
    if (sio) begin
      io = '{addr: 6'(a - PCF_IO_SHIFT), we: 1'b1, re: 1'b0, wdata: d};
    end else begin
      ds = '{addr: a, we: 1'b1, re: 1'b0, wdata: d};
    end
    tick(1);
    io = '0;
    ds = '0;
    tick(1);
  endtask : wr

  // register read; data stands from the edge that takes the strobe
  task automatic rd(input logic [15:0] a, input bit sio,
                    output logic [7:0] d);
    if (sio) begin
      io = '{addr: 6'(a - PCF_IO_SHIFT), we: 1'b0, re: 1'b1, wdata: 8'h00};
    end else begin
      ds = '{addr: a, we: 1'b0, re: 1'b1, wdata: 8'h00};
    end
    tick(1);
    d = rdata_o;
    io = '0;
    ds = '0;
    tick(1);
  endtask : rd

  // verdict and the end of the run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ceiling well above the roughly 730 cycles the scenarios need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    tick(16);
    rst_i = 1'b0;
    // reset values, unmapped offset reads zero
    foreach (all[i]) begin
      rd(all[i], 1'b0, q);
      check("reset value", q, 8'h00);
    end
    // random masks, then short i/o sweep must not reach them
    for (int g = 0; g < 4; g++) begin
      seed = xs(seed);
      msk[g] = seed[7:0];
      wr(mofs[g], seed[7:0], 1'b0);
      rd(mofs[g], 1'b0, q);
      check("mask", q, msk[g]);
    end
    for (int a = 32; a < 96; a++) begin
      wr(16'(a), 8'hFF, 1'b1);
    end
    for (int g = 0; g < 4; g++) begin
      rd(mofs[g], 1'b0, q);
      check("mask after i/o sweep", q, msk[g]);
    end
    wr(PCF_OFS_GRP_EN, 8'h0F, 1'b0);
    rd(PCF_OFS_GRP_EN, 1'b0, q);
    check("group enable", q, 8'h0F);
    // random pin toggles against the flag model
    gie_i = 1'b1;
    for (int r = 0; r < 40; r++) begin
      seed = xs(seed);
      for (int g = 0; g < 4; g++) begin
        if (((seed >> (8 * g)) & msk[g] & 255) != 0) begin
          m_pc[g] = 1'b1;
        end
      end
      want[31:0] = want[31:0] ^ seed;
      tick(6);
      check("requests", irq_req_o, {m_pc[3:0], 2'b00});
      rd(PCF_OFS_PC_FLAGS, 1'b1, q);
      check("flags via i/o", q, m_pc);
      seed = xs(seed);
      if (seed[8]) begin
        wr(PCF_OFS_PC_FLAGS, seed[7:0], seed[9]);
        m_pc[3:0] = m_pc[3:0] & ~seed[3:0];
      end else begin
        ack[2 + seed[1:0]] = 1'b1;
        tick(1);
        ack = 6'h00;
        m_pc[seed[1:0]] = 1'b0;
        tick(1);
      end
      rd(PCF_OFS_PC_FLAGS, 1'b0, q);
      check("flags after clear", q, m_pc);
    end
    gie_i = 1'b0;
    tick(1);
    check("requests without global", irq_req_o, 6'h00);
    // external pins: rise on one, fall on zero, low level, any change
    gie_i = 1'b1;
    en_i = 2'h3;
    sc[1] = 2'b11;
    tick(1);
    want[33] = 1'b1;
    tick(6);
    m_ext = 8'h02;
    rd(PCF_OFS_EXT_FLAGS, 1'b0, q);
    check("ext flag rise", q, m_ext);
    check("ext one request", irq_req_o[1], 1'b1);
    ack[1] = 1'b1;
    tick(1);
    ack = 6'h00;
    m_ext = 8'h00;
    tick(1);
    rd(PCF_OFS_EXT_FLAGS, 1'b0, q);
    check("ext flag after entry", q, m_ext);
    sc[0] = 2'b10;
    tick(1);
    want[32] = 1'b1;
    tick(6);
    rd(PCF_OFS_EXT_FLAGS, 1'b0, q);
    check("ext rise in fall mode", q, m_ext);
    want[32] = 1'b0;
    tick(6);
    m_ext = 8'h01;
    rd(PCF_OFS_EXT_FLAGS, 1'b1, q);
    check("ext flag fall", q, m_ext);
    wr(PCF_OFS_EXT_FLAGS, 8'h01, 1'b1);
    m_ext = 8'h00;
    rd(PCF_OFS_EXT_FLAGS, 1'b0, q);
    check("ext flag write one", q, m_ext);
    sc[0] = 2'b00;
    tick(2);
    check("low level request", irq_req_o[0], 1'b1);
    rd(PCF_OFS_EXT_FLAGS, 1'b0, q);
    check("low level flag", q, m_ext);
    want[32] = 1'b1;
    tick(6);
    check("high level no request", irq_req_o[0], 1'b0);
    sc[1] = 2'b01;
    tick(1);
    want[33] = 1'b0;
    tick(6);
    m_ext = 8'h02;
    rd(PCF_OFS_EXT_FLAGS, 1'b0, q);
    check("ext any change", q, m_ext);
    // reset in mid-run clears flags and masks
    gie_i = 1'b0;
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
    m_pc = 8'h00;
    m_ext = 8'h00;
    check("requests after reset", irq_req_o, 6'h00);
    rd(PCF_OFS_PC_FLAGS, 1'b0, q);
    check("flags after reset", q, m_pc);
    rd(PCF_OFS_MASK0, 1'b0, q);
    check("mask after reset", q, 8'h00);
    rd(PCF_OFS_EXT_FLAGS, 1'b0, q);
    check("ext flags after reset", q, m_ext);
    end_of_test();
  end
endmodule : test_pin_change_ext_irq_flags
`default_nettype wire

/* verilog/pcf_irq_flags.sv */
// external and pin-change interrupt flags with their registers
// Functional notes
// - a selected trigger on external pin one sets its flag
// - a selected trigger on external pin zero sets its flag
// - enabled external flag requests its vector; entry clears the flag
// - writing one clears a flag; writing zero leaves it
// - low-level sensing keeps the external flag cleared
// - group 3 covers sources 31..24, gated by its enable and global
// - group 2 covers sources 23..16, gated by its enable and global
// - group 1 covers sources 15..8, gated by its enable and global
// - group 0 covers sources 7..0, gated by its enable and global
// - change on an unmasked pin of group n sets flag bit n
// - enabled group flag requests its vector; entry clears the flag
// - mask group0 bits enable detection on pins 7..0
// - mask group1 bits enable detection on pins 15..8
// - mask group2 bits enable detection on pins 23..16
// - mask group3 bits enable detection on pins 31..24
// - low registers also answer short i/o at offset minus 0x20
// - extended registers from 0x60 answer data-space access only
// - pin-change flags answer short i/o at 0x1B
// - sense codes: 00 low, 01 any change, 10 falling, 11 rising
`timescale 1ns/100ps
`default_nettype none
module pcf_irq_flags
  import pcf_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // pins
  input  wire logic [PCF_PINS-1:0]      pin_change_source_i,
  input  wire logic                     ext_irq_pin_zero_i,
  input  wire logic                     ext_irq_pin_one_i,
  // settings held by neighbouring logic
  input  wire logic                     gie_i,
  input  wire logic [PCF_EXT-1:0]       ext_irq_enable_i,
  input  wire logic [1:0]               sense_control_zero_i,
  input  wire logic [1:0]               sense_control_one_i,
  // core register accesses
  input  wire pcf_ds_req_t              ds_req_i,
  input  wire pcf_io_req_t              io_req_i,
  output logic      [7:0]               rdata_o,
  // vectored requests and handler entry
  output logic      [PCF_SRCS-1:0]      irq_req_o,
  input  wire logic [PCF_SRCS-1:0]      irq_ack_i
);

  logic [PCF_PINS-1:0]     pc_lvl;
  logic [PCF_PINS-1:0]     pc_prv;
  logic [PCF_EXT-1:0]      ex_lvl;
  logic [PCF_EXT-1:0]      ex_prv;
  logic [PCF_GROUPS-1:0]   pc_flags;
  logic [PCF_EXT-1:0]      ext_flags;
  logic [PCF_GROUPS-1:0]   grp_en;
  logic [7:0]              mask [PCF_GROUPS];
  logic [PCF_GROUPS-1:0]   pc_set;
  logic [PCF_EXT-1:0]      ex_set;
  logic [PCF_EXT-1:0]      ex_low;
  logic [PCF_EXT-1:0]      ex_lvl_req;
  logic [15:0]             acc_addr;
  logic                    acc_we;
  logic                    acc_re;
  logic [7:0]              acc_wdata;
  logic [PCF_GROUPS-1:0]   pc_clr;
  logic [PCF_EXT-1:0]      ex_clr;
  logic [1:0]              sense [PCF_EXT];

  assign sense[0] = sense_control_zero_i;
  assign sense[1] = sense_control_one_i;

  // pin synchronisers: all 32 sources in one bank
  pcf_sync_edge #(.WIDTH(PCF_PINS)) u_pc_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (pin_change_source_i),
    .level_o (pc_lvl),
    .prev_o  (pc_prv)
  );

  // external pins share the same synchroniser style
  pcf_sync_edge #(.WIDTH(PCF_EXT)) u_ex_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   ({ext_irq_pin_one_i, ext_irq_pin_zero_i}),
    .level_o (ex_lvl),
    .prev_o  (ex_prv)
  );

  // merge the two access paths; short i/o is lifted by the shift
  always_comb begin
    if (io_req_i.we || io_req_i.re) begin
      acc_addr  = {10'h000, io_req_i.addr} + PCF_IO_SHIFT;
      acc_we    = io_req_i.we;
      acc_re    = io_req_i.re;
      acc_wdata = io_req_i.wdata;
    end else begin
      acc_addr  = ds_req_i.addr;
      acc_we    = ds_req_i.we;
      acc_re    = ds_req_i.re;
      acc_wdata = ds_req_i.wdata;
    end
  end
  // short i/o tops out at 0x5F, so the block from 0x60 is data-only

  // per-group detection: unmasked change in the group sets the flag
  generate
    for (genvar g = 0; g < PCF_GROUPS; g++) begin : g_grp
      assign pc_set[g] = |((pc_lvl[g*PCF_GRP_PINS +: PCF_GRP_PINS]
                            ^ pc_prv[g*PCF_GRP_PINS +: PCF_GRP_PINS])
                           & mask[g]);
      assign irq_req_o[PCF_REQ_GRP0+g] = pc_flags[g] & grp_en[g]
                                         & gie_i;
    end
  endgenerate

  // per-pin external triggers by sense code
  generate
    for (genvar e = 0; e < PCF_EXT; e++) begin : g_ext
      always_comb begin
        unique case (pcf_sense_t'(sense[e]))
          PCF_SENSE_LOW:  ex_set[e] = 1'b0;
          PCF_SENSE_ANY:  ex_set[e] = ex_lvl[e] ^ ex_prv[e];
          PCF_SENSE_FALL: ex_set[e] = ex_prv[e] & ~ex_lvl[e];
          PCF_SENSE_RISE: ex_set[e] = ex_lvl[e] & ~ex_prv[e];
        endcase
      end
      assign ex_low[e]     = (sense[e] == PCF_SENSE_LOW);
      // level mode asks directly from the pin, not from the flag
      assign ex_lvl_req[e] = ex_low[e] & ~ex_lvl[e];
      assign irq_req_o[e]  = (ext_flags[e] | ex_lvl_req[e])
                             & ext_irq_enable_i[e] & gie_i;
    end
  endgenerate

  // clear sources: write-one and handler entry
  assign pc_clr = ((acc_we && acc_addr == PCF_OFS_PC_FLAGS)
                   ? acc_wdata[PCF_GROUPS-1:0] : PCF_RST_NIB)
                  | irq_ack_i[PCF_SRCS-1:PCF_REQ_GRP0];
  assign ex_clr = ((acc_we && acc_addr == PCF_OFS_EXT_FLAGS)
                   ? acc_wdata[PCF_EXT-1:0] : PCF_RST_EXT)
                  | irq_ack_i[PCF_REQ_EXT1:PCF_REQ_EXT0];

  // pin-change flags; a set in the clearing cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_flags <= PCF_RST_NIB;
    end else begin
      pc_flags <= (pc_flags & ~pc_clr) | pc_set;
    end
  end

  // external flags; level sensing pins them low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_flags <= PCF_RST_EXT;
    end else begin
      ext_flags <= ((ext_flags & ~ex_clr) | ex_set)
                   & ~ex_low;
    end
  end

  // enable and mask registers, data-space only above 0x60
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      grp_en <= PCF_RST_NIB;
      for (int i = 0; i < PCF_GROUPS; i++) begin
        mask[i] <= PCF_RST_BYTE;
      end
    end else if (acc_we) begin
      unique case (acc_addr)
        PCF_OFS_GRP_EN: grp_en  <= acc_wdata[PCF_GROUPS-1:0];
        PCF_OFS_MASK0:  mask[0] <= acc_wdata;
        PCF_OFS_MASK1:  mask[1] <= acc_wdata;
        PCF_OFS_MASK2:  mask[2] <= acc_wdata;
        PCF_OFS_MASK3:  mask[3] <= acc_wdata;
        default: ;
      endcase
    end
  end

  // read data registered; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= PCF_RST_BYTE;
    end else if (acc_re) begin
      unique case (acc_addr)
        PCF_OFS_PC_FLAGS:  rdata_o <= {4'h0, pc_flags};
        PCF_OFS_EXT_FLAGS: rdata_o <= {6'h00, ext_flags};
        PCF_OFS_GRP_EN:    rdata_o <= {4'h0, grp_en};
        PCF_OFS_MASK0:     rdata_o <= mask[0];
        PCF_OFS_MASK1:     rdata_o <= mask[1];
        PCF_OFS_MASK2:     rdata_o <= mask[2];
        PCF_OFS_MASK3:     rdata_o <= mask[3];
        default:           rdata_o <= PCF_RST_BYTE;
      endcase
    end
  end

  // checks on the flag, request and access behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_flag_w1c_clear: assert property (
    (acc_we && acc_addr == PCF_OFS_PC_FLAGS && pc_set == 4'h0)
    |=> (pc_flags & $past(acc_wdata[3:0])) == 4'h0)
    else $error("pin-change flag not cleared by write of one");

  a_flag_w0_keep: assert property (
    (acc_we && acc_addr == PCF_OFS_PC_FLAGS && irq_ack_i == 6'h00)
    |=> (pc_flags & $past(pc_flags) & ~$past(acc_wdata[3:0]))
        == ($past(pc_flags) & ~$past(acc_wdata[3:0])))
    else $error("pin-change flag lost on write of zero");

  a_set_beats_clr: assert property (
    (pc_set != 4'h0) |=> ((pc_flags & $past(pc_set)) == $past(pc_set)))
    else $error("pin-change event lost");

  a_mask_gates_set: assert property (
    (mask[0] == 8'h00) |-> !pc_set[0])
    else $error("masked pin set group 0 flag");

  a_pin_to_req: assert property (
    (gie_i && grp_en[0] && mask[0][0] && pc_lvl[0] != pc_prv[0]
     && !irq_ack_i[2])
    ##1 (gie_i && grp_en[0]) |-> irq_req_o[PCF_REQ_GRP0])
    else $error("group 0 change did not raise request");

  a_low_keeps_clr: assert property (
    (sense[0] == 2'b00) |=> !ext_flags[0])
    else $error("external flag set in low-level mode");

  a_rise_sets_flag: assert property (
    (sense[1] == 2'b11 && ex_lvl[1] && !ex_prv[1]) |=> ext_flags[1])
    else $error("rising edge missed on external pin one");

  a_ack_clears: assert property (
    (irq_ack_i[0] && !ex_set[0]) |=> !ext_flags[0])
    else $error("handler entry did not clear external flag");

  a_req_needs_gie: assert property (
    !gie_i |-> irq_req_o == 6'h00)
    else $error("request with global enable off");

  a_io_read_map: assert property (
    (io_req_i.re && io_req_i.addr == 6'h1B)
    |=> rdata_o == {4'h0, $past(pc_flags)})
    else $error("short i/o read of flags wrong");

  c_group_req: cover property (irq_req_o[PCF_REQ_GRP0+3]);
  c_ext_fall: cover property (sense[0] == 2'b10 ##1 ext_flags[0]);
  c_set_and_clr: cover property (pc_set[1] && pc_clr[1]);

endmodule : pcf_irq_flags
`default_nettype wire

/* verilog/pcf_pkg.sv */
// package: offsets, field layout, sense codes and access carriers
package pcf_pkg;

  // data-space offsets of the registers held here
  localparam logic [15:0] PCF_OFS_PC_FLAGS  = 16'h003B;
  localparam logic [15:0] PCF_OFS_EXT_FLAGS = 16'h003C;
  localparam logic [15:0] PCF_OFS_GRP_EN    = 16'h0068;
  localparam logic [15:0] PCF_OFS_MASK0     = 16'h006B;
  localparam logic [15:0] PCF_OFS_MASK1     = 16'h006C;
  localparam logic [15:0] PCF_OFS_MASK2     = 16'h006D;
  localparam logic [15:0] PCF_OFS_MASK3     = 16'h0073;

  // short i/o space: offset below data space, and its top
  localparam logic [15:0] PCF_IO_SHIFT      = 16'h0020;
  localparam logic [5:0]  PCF_IO_TOP        = 6'h3F;
  localparam logic [15:0] PCF_EXT_IO_BASE   = 16'h0060;

  // widths and counts
  localparam int          PCF_GROUPS        = 4;
  localparam int          PCF_GRP_PINS      = 8;
  localparam int          PCF_PINS          = 32;
  localparam int          PCF_EXT           = 2;
  localparam int          PCF_SRCS          = 6;

  // bit positions inside the request vector
  localparam int          PCF_REQ_EXT0      = 0;
  localparam int          PCF_REQ_EXT1      = 1;
  localparam int          PCF_REQ_GRP0      = 2;

  // reset values
  localparam logic [7:0]  PCF_RST_BYTE      = 8'h00;
  localparam logic [3:0]  PCF_RST_NIB       = 4'h0;
  localparam logic [1:0]  PCF_RST_EXT       = 2'h0;

  // trigger selection of an external pin
  typedef enum logic [1:0] {
    PCF_SENSE_LOW  = 2'b00,
    PCF_SENSE_ANY  = 2'b01,
    PCF_SENSE_FALL = 2'b10,
    PCF_SENSE_RISE = 2'b11
  } pcf_sense_t;

  // data-space load/store access
  typedef struct packed {
    logic [15:0] addr;
    logic        we;
    logic        re;
    logic [7:0]  wdata;
  } pcf_ds_req_t;

  // short i/o instruction access
  typedef struct packed {
    logic [5:0] addr;
    logic       we;
    logic       re;
    logic [7:0] wdata;
  } pcf_io_req_t;

endpackage : pcf_pkg

/* verilog/pcf_sync_edge.sv */
// two-stage pin synchroniser with a previous-value stage
`timescale 1ns/100ps
`default_nettype none
module pcf_sync_edge #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // raw pins
  input  wire logic [WIDTH-1:0] pin_i,
  // synchronised level and its previous value
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] prev_o
);

  logic [WIDTH-1:0] meta;

  // first stage is read by the second stage only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta    <= '0;
      level_o <= '0;
      prev_o  <= '0;
    end else begin
      meta    <= pin_i;
      level_o <= meta;
      prev_o  <= level_o; // change seen as level vs prev
    end
  end

endmodule : pcf_sync_edge
`default_nettype wire
